// *** logic/spi_eeprom_device.sv ***
// eeprom end of the spi link: sampler, command engine, array and write timer
// Summary of operation
// - mode 0 and mode 3 both work
// - accepted write completes alone within 5 ms
// - block protect quarter, half or whole array
// - selected only while chip select low
// - deselected: input ignored, output released
// - master selects once before first command
// - chip select pulled up during power-up
// - output bit changes after falling sck
// - input bit sampled on rising sck
// - all inbound bits travel on serial input
// - protect pin high allows reads and writes
// - protect pin low refuses all writes
// - protect drop while selected abandons write
// - started internal write ignores protect pin
// - suspend acts only mid-sequence while selected
// - suspend keeps partial sequence intact
// - master enters suspend with sck low
// - master leaves suspend with sck low
// - sck edges during suspend are ignored
// - suspended: input ignored, output released
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_device #(
  parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // link
  spi_link_if.device link,
  // state seen by the user side
  output logic write_busy,
  output logic suspended
);
  localparam int N = spi_eeprom_pkg::NUM_IN;
  localparam int AW = spi_eeprom_pkg::ADDR_W;
  localparam int TW = spi_eeprom_pkg::TIMER_W;

  logic [N-1:0] pins;
  logic [N-1:0] s1, s2, s3, filt;
  logic [7:0] mem [spi_eeprom_pkg::MEM_DEPTH];

  spi_eeprom_pkg::phase_t phase, next_phase;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] sreg, next_sreg;
  logic [7:0] out_sreg, next_out_sreg;
  logic [7:0] opcode, next_opcode;
  logic [AW-1:0] addr, next_addr;
  logic so_q, next_so_q;
  logic so_en, next_so_en;
  logic paused, next_paused;
  logic sck_prev, next_sck_prev;
  logic wel, next_wel;
  logic [1:0] bp, next_bp;
  logic pend_valid, next_pend_valid;
  logic pend_sr, next_pend_sr;
  logic [7:0] pend_data, next_pend_data;
  logic [AW-1:0] pend_addr, next_pend_addr;
  logic busy, next_busy;
  logic [TW-1:0] timer, next_timer;
  logic mem_we;
  logic selected, sck_f, si_f, wp_high, hold_high, rise, fall;
  logic [7:0] status, byte_in;
  logic [AW-1:0] addr_inc;

  assign pins = {link.hold_n, link.wp_n, link.si, link.sck, link.cs_n};

  // three-stage sampler; a change counts once stages two and three agree
  generate
    for (genvar i = 0; i < N; i++) begin : g_sync
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          s1[i] <= spi_eeprom_pkg::SYNC_RESET[i];
          s2[i] <= spi_eeprom_pkg::SYNC_RESET[i];
          s3[i] <= spi_eeprom_pkg::SYNC_RESET[i];
          filt[i] <= spi_eeprom_pkg::SYNC_RESET[i];
        end else begin
          s1[i] <= pins[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            filt[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

  // starts deselected so the first frame needs a real falling select
  assign selected = ~filt[spi_eeprom_pkg::IN_CS];
  assign sck_f = filt[spi_eeprom_pkg::IN_SCK];
  assign si_f = filt[spi_eeprom_pkg::IN_SI];
  assign wp_high = filt[spi_eeprom_pkg::IN_WP];
  assign hold_high = filt[spi_eeprom_pkg::IN_HOLD];
  // edges only, never levels, so mode 3 idle-high clock is harmless
  assign rise = sck_f & ~sck_prev;
  assign fall = ~sck_f & sck_prev;
  assign byte_in = {sreg[6:0], si_f};
  assign addr_inc = addr + 1'b1;

  always_comb begin
    status = 8'h00;
    status[spi_eeprom_pkg::ST_BUSY] = busy;
    status[spi_eeprom_pkg::ST_WEL] = wel;
    status[spi_eeprom_pkg::ST_BP_HI:spi_eeprom_pkg::ST_BP_LO] = bp;
  end

  function automatic logic is_protected(input logic [1:0] level, input logic [AW-1:0] a);
    logic result;
    result = 1'b0;
    case (level)
      spi_eeprom_pkg::BP_QUARTER: result = &a[AW-1:AW-2];
      spi_eeprom_pkg::BP_HALF: result = a[AW-1];
      spi_eeprom_pkg::BP_ALL: result = 1'b1;
      default: result = 1'b0;
    endcase
    return result;
  endfunction : is_protected

  always_comb begin
    next_phase = phase;
    next_bitcnt = bitcnt;
    next_sreg = sreg;
    next_out_sreg = out_sreg;
    next_opcode = opcode;
    next_addr = addr;
    next_so_q = so_q;
    next_so_en = so_en;
    next_paused = paused;
    next_sck_prev = sck_f;
    next_wel = wel;
    next_bp = bp;
    next_pend_valid = pend_valid;
    next_pend_sr = pend_sr;
    next_pend_data = pend_data;
    next_pend_addr = pend_addr;
    next_busy = busy;
    next_timer = timer;
    mem_we = 1'b0;
    // self-timed cycle runs on the system clock, no sck needed
    if (busy) begin
      if (timer == TW'(WRITE_CYCLES - 1)) begin
        next_busy = 1'b0;
        next_pend_valid = 1'b0;
        next_wel = 1'b0;
        mem_we = ~pend_sr;
        if (pend_sr) begin
          next_bp = pend_data[spi_eeprom_pkg::ST_BP_HI:spi_eeprom_pkg::ST_BP_LO];
        end
      end else begin
        next_timer = timer + 1'b1;
      end
    end
    if (!selected) begin
      next_phase = spi_eeprom_pkg::PH_OP;
      next_bitcnt = 3'h0;
      next_paused = 1'b0;
      next_so_en = 1'b0;
      if (pend_valid && !busy) begin
        if (wp_high) begin
          next_busy = 1'b1;
          next_timer = '0;
        end else begin
          next_pend_valid = 1'b0;
        end
      end
    end else begin
      // a write still being shifted in dies with the protect pin
      if (!wp_high && !busy) begin
        next_pend_valid = 1'b0;
        if (phase == spi_eeprom_pkg::PH_WDATA || phase == spi_eeprom_pkg::PH_WSR ||
            (phase == spi_eeprom_pkg::PH_ADDR && opcode == spi_eeprom_pkg::OP_WRITE)) begin
          next_phase = spi_eeprom_pkg::PH_DONE;
        end
      end
      if (paused) begin
        next_paused = !(hold_high && !sck_f);
      end else begin
        next_paused = !hold_high && !sck_f && (bitcnt != 3'h0 || phase != spi_eeprom_pkg::PH_OP);
      end
      // no shifting at all while suspended, state simply waits
      if (!paused) begin
        if (fall) begin
          next_so_q = out_sreg[7];
          next_out_sreg = {out_sreg[6:0], 1'b0};
          next_so_en = (phase == spi_eeprom_pkg::PH_RDATA);
        end
        if (rise) begin
          next_sreg = byte_in;
          next_bitcnt = bitcnt + 1'b1;
          if (bitcnt == spi_eeprom_pkg::LAST_BIT) begin
            unique case (phase)
              spi_eeprom_pkg::PH_OP: begin
                next_opcode = byte_in;
                next_phase = spi_eeprom_pkg::PH_DONE;
                if (byte_in == spi_eeprom_pkg::OP_RDSR) begin
                  next_out_sreg = status;
                  next_phase = spi_eeprom_pkg::PH_RDATA;
                end else if (!busy) begin
                  if (byte_in == spi_eeprom_pkg::OP_READ) begin
                    next_phase = spi_eeprom_pkg::PH_ADDR;
                  end else if (byte_in == spi_eeprom_pkg::OP_WRITE && wel && wp_high) begin
                    next_phase = spi_eeprom_pkg::PH_ADDR;
                  end else if (byte_in == spi_eeprom_pkg::OP_WRSR && wel && wp_high) begin
                    next_phase = spi_eeprom_pkg::PH_WSR;
                  end else if (byte_in == spi_eeprom_pkg::OP_WREN) begin
                    next_wel = 1'b1;
                  end else if (byte_in == spi_eeprom_pkg::OP_WRDI) begin
                    next_wel = 1'b0;
                  end
                end
              end
              spi_eeprom_pkg::PH_ADDR: begin
                next_addr = byte_in[AW-1:0];
                if (opcode == spi_eeprom_pkg::OP_READ) begin
                  next_out_sreg = mem[byte_in[AW-1:0]];
                  next_phase = spi_eeprom_pkg::PH_RDATA;
                end else begin
                  next_phase = spi_eeprom_pkg::PH_WDATA;
                end
              end
              spi_eeprom_pkg::PH_WDATA: begin
                // one byte per frame; later bytes are dropped
                if (!is_protected(bp, addr) && wp_high) begin
                  next_pend_valid = 1'b1;
                  next_pend_sr = 1'b0;
                  next_pend_data = byte_in;
                  next_pend_addr = addr;
                end
                next_phase = spi_eeprom_pkg::PH_DONE;
              end
              spi_eeprom_pkg::PH_WSR: begin
                next_pend_valid = 1'b1;
                next_pend_sr = 1'b1;
                next_pend_data = byte_in;
                next_phase = spi_eeprom_pkg::PH_DONE;
              end
              spi_eeprom_pkg::PH_RDATA: begin
                if (opcode == spi_eeprom_pkg::OP_READ) begin
                  next_addr = addr_inc;
                  next_out_sreg = mem[addr_inc];
                end else begin
                  next_out_sreg = status;
                end
              end
              spi_eeprom_pkg::PH_DONE: begin
                next_phase = spi_eeprom_pkg::PH_DONE;
              end
              default: next_phase = spi_eeprom_pkg::PH_DONE;
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase <= spi_eeprom_pkg::PH_OP;
      bitcnt <= 3'h0;
      sreg <= 8'h00;
      out_sreg <= 8'h00;
      opcode <= 8'h00;
      addr <= '0;
      so_q <= 1'b0;
      so_en <= 1'b0;
      paused <= 1'b0;
      sck_prev <= 1'b0;
      wel <= 1'b0;
      bp <= spi_eeprom_pkg::BP_NONE;
      pend_valid <= 1'b0;
      pend_sr <= 1'b0;
      pend_data <= 8'h00;
      pend_addr <= '0;
      busy <= 1'b0;
      timer <= '0;
    end else begin
      phase <= next_phase;
      bitcnt <= next_bitcnt;
      sreg <= next_sreg;
      out_sreg <= next_out_sreg;
      opcode <= next_opcode;
      addr <= next_addr;
      so_q <= next_so_q;
      so_en <= next_so_en;
      paused <= next_paused;
      sck_prev <= next_sck_prev;
      wel <= next_wel;
      bp <= next_bp;
      pend_valid <= next_pend_valid;
      pend_sr <= next_pend_sr;
      pend_data <= next_pend_data;
      pend_addr <= next_pend_addr;
      busy <= next_busy;
      timer <= next_timer;
    end
  end

  // array has no reset; contents are unknown until written
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[pend_addr] <= pend_data;
    end
  end

  assign link.so = so_q;
  assign link.so_oe = so_en & selected & ~paused;
  assign write_busy = busy;
  assign suspended = paused;
endmodule : spi_eeprom_device
`default_nettype wire

// *** logic/spi_eeprom_host.sv ***
// bus master end of the spi link: mode 0 byte shifter with suspend control
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_host (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // link
  spi_link_if.host link,
  // byte stream from the user
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // byte stream to the user
  output logic rx_valid,
  output logic [7:0] rx_data,
  // pin control
  input wire logic hold_req,
  input wire logic protect,
  output logic in_frame
);
  localparam int HW = spi_eeprom_pkg::HALF_W;

  spi_eeprom_pkg::host_state_t state, next_state;
  logic [HW-1:0] cnt, next_cnt;
  logic [2:0] bitn, next_bitn;
  logic [7:0] shift, next_shift;
  logic [7:0] rx, next_rx;
  logic [7:0] rx_out, next_rx_out;
  logic rx_pulse, next_rx_pulse;
  logic last_q, next_last_q;
  logic cs_n, next_cs_n;
  logic sck, next_sck;
  logic si, next_si;
  logic hold_n, next_hold_n;
  logic wp_n, next_wp_n;
  logic s1, s2, s3, so_f;
  logic half_done;

  // three-stage sampler on the returning data line
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      so_f <= 1'b1;
    end else begin
      s1 <= link.so_line;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        so_f <= s3;
      end
    end
  end

  assign half_done = (cnt == HW'(spi_eeprom_pkg::SCK_HALF - 1));
  assign tx_ready = (state == spi_eeprom_pkg::H_IDLE) || (state == spi_eeprom_pkg::H_NEXT);

  always_comb begin
    next_state = state;
    next_cnt = half_done ? '0 : cnt + 1'b1;
    next_bitn = bitn;
    next_shift = shift;
    next_rx = rx;
    next_rx_out = rx_out;
    next_rx_pulse = 1'b0;
    next_last_q = last_q;
    next_cs_n = cs_n;
    next_sck = sck;
    next_si = si;
    next_hold_n = hold_n;
    next_wp_n = ~protect;
    unique case (state)
      spi_eeprom_pkg::H_IDLE, spi_eeprom_pkg::H_NEXT: begin
        next_cnt = '0;
        if (tx_valid) begin
          next_cs_n = 1'b0;
          next_shift = tx_data;
          next_si = tx_data[7];
          next_last_q = tx_last;
          next_bitn = 3'h0;
          next_state = spi_eeprom_pkg::H_LOW;
        end
      end
      spi_eeprom_pkg::H_LOW: begin
        if (half_done) begin
          if (hold_req) begin
            next_hold_n = 1'b0;
            next_state = spi_eeprom_pkg::H_HOLD;
          end else begin
            next_sck = 1'b1;
            next_rx = {rx[6:0], so_f};
            next_state = spi_eeprom_pkg::H_HIGH;
          end
        end
      end
      spi_eeprom_pkg::H_HIGH: begin
        if (half_done) begin
          next_sck = 1'b0;
          if (bitn == spi_eeprom_pkg::LAST_BIT) begin
            next_rx_out = rx;
            next_rx_pulse = 1'b1;
            if (last_q) begin
              next_cs_n = 1'b1;
              next_si = 1'b0;
              next_state = spi_eeprom_pkg::H_IDLE;
            end else begin
              next_state = spi_eeprom_pkg::H_NEXT;
            end
          end else begin
            next_bitn = bitn + 1'b1;
            next_shift = {shift[6:0], 1'b0};
            next_si = shift[6];
            next_state = spi_eeprom_pkg::H_LOW;
          end
        end
      end
      spi_eeprom_pkg::H_HOLD: begin
        // sck stays low for the whole pause and a full half after it
        next_cnt = '0;
        if (!hold_req) begin
          next_hold_n = 1'b1;
          next_state = spi_eeprom_pkg::H_LOW;
        end
      end
      default: next_state = spi_eeprom_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= spi_eeprom_pkg::H_IDLE;
      cnt <= '0;
      bitn <= 3'h0;
      shift <= 8'h00;
      rx <= 8'h00;
      rx_out <= 8'h00;
      rx_pulse <= 1'b0;
      last_q <= 1'b0;
      cs_n <= 1'b1;
      sck <= 1'b0;
      si <= 1'b0;
      hold_n <= 1'b1;
      wp_n <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      shift <= next_shift;
      rx <= next_rx;
      rx_out <= next_rx_out;
      rx_pulse <= next_rx_pulse;
      last_q <= next_last_q;
      cs_n <= next_cs_n;
      sck <= next_sck;
      si <= next_si;
      hold_n <= next_hold_n;
      wp_n <= next_wp_n;
    end
  end

  assign link.cs_n = cs_n;
  assign link.sck = sck;
  assign link.si = si;
  assign link.hold_n = hold_n;
  assign link.wp_n = wp_n;
  assign rx_valid = rx_pulse;
  assign rx_data = rx_out;
  assign in_frame = ~cs_n;
endmodule : spi_eeprom_host
`default_nettype wire

// *** logic/spi_eeprom_pkg.sv ***
// shared constants and types for the serial eeprom link
`default_nettype none
package spi_eeprom_pkg;
  localparam int CLOCK_HZ = 100_000_000;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES = (WRITE_TIME_MS * (CLOCK_HZ / 1000));
  localparam int TIMER_W = 20;
  // host sck half period in clocks; long enough to cover both synchronisers
  localparam int SCK_HALF = 16;
  localparam int HALF_W = 5;
  localparam int ADDR_W = 7;
  localparam int MEM_DEPTH = 128;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam int IN_CS = 0;
  localparam int IN_SCK = 1;
  localparam int IN_SI = 2;
  localparam int IN_WP = 3;
  localparam int IN_HOLD = 4;
  localparam int NUM_IN = 5;
  // deselected, clock low, protect and suspend inactive
  localparam logic [NUM_IN-1:0] SYNC_RESET = 5'h19;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [2:0] {
    PH_OP = 3'b000,
    PH_ADDR = 3'b001,
    PH_WDATA = 3'b010,
    PH_RDATA = 3'b011,
    PH_WSR = 3'b100,
    PH_DONE = 3'b101
  } phase_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW = 3'b001,
    H_HIGH = 3'b010,
    H_NEXT = 3'b011,
    H_HOLD = 3'b100
  } host_state_t;
endpackage : spi_eeprom_pkg
`default_nettype wire

// *** logic/spi_link_if.sv ***
// spi link between the bus master and the eeprom front end
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic wp_n;
  logic hold_n;
  logic so_line;
  // released output floats high through a pull-up
  assign so_line = so_oe ? so : 1'b1;
  modport device (input cs_n, input sck, input si, input wp_n, input hold_n, output so, output so_oe);
  modport host (output cs_n, output sck, output si, output wp_n, output hold_n, input so_line);
endinterface : spi_link_if
`default_nettype wire

// *** verif/spi_eeprom_asserts.sv ***
// concurrent checks on the spi link between the two ends
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_asserts #(
  parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so,
  input wire logic so_oe,
  input wire logic wp_n,
  input wire logic hold_n,
  // device state
  input wire logic write_busy,
  input wire logic suspended
);
  int busy_cnt;
  int next_busy_cnt;
  always_comb begin
    next_busy_cnt = write_busy ? busy_cnt + 1 : 0;
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // six clocks cover the pin sampler and the output register
  sequence deselect_held;
    cs_n [*6];
  endsequence
  sequence pause_held;
    !hold_n [*6];
  endsequence
  a_deselect_release: assert property (deselect_held |-> !so_oe)
    else $error("output driven while deselected");
  a_pause_release: assert property (pause_held |-> !so_oe)
    else $error("output driven while paused");
  a_out_on_fall: assert property (so_oe && $changed(so) |-> !sck)
    else $error("output changed with clock high");
  a_drive_selected: assert property ($rose(so_oe) |-> !cs_n && hold_n)
    else $error("output enabled outside selection");
  a_pause_cause: assert property ($rose(suspended) |-> !cs_n && !hold_n && !sck)
    else $error("pause without select and low clock");
  a_write_bound: assert property (write_busy |-> busy_cnt <= WRITE_CYCLES)
    else $error("write cycle too long");
  a_write_full: assert property ($fell(write_busy) |-> busy_cnt >= WRITE_CYCLES - 1)
    else $error("write cycle cut short");
  a_write_start: assert property ($rose(write_busy) |-> cs_n && $past(wp_n, 8))
    else $error("write started while selected or protected");
  a_mode_idle: assert property ($fell(cs_n) |-> !sck)
    else $error("clock not idle low at select");
endmodule : spi_eeprom_asserts
`default_nettype wire

// *** verif/spi_eeprom_pin_interface_tb.sv ***
// bench joining host and eeprom ends with a byte-level memory model
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_pin_interface_tb;
  localparam int WCYC = 60;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic tx_valid = 1'b0;
  logic tx_last = 1'b0;
  logic hold_req = 1'b0;
  logic protect = 1'b0;
  logic saw_susp = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic write_busy, suspended, tx_ready, rx_valid, in_frame;
  logic [7:0] rx_data;
  logic [7:0] rxq[$];
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32'h108b36a1;
  int mem[128];
  int bp = 0;
  int bps[5] = '{0, 1, 2, 3, 0};
  int adr[3] = '{32'h3f, 32'h5f, 32'h60};
  spi_link_if link();
  spi_eeprom_host spi_eeprom_host_inst(.clock(clock), .reset(reset), .link(link.host), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .hold_req(hold_req), .protect(protect), .in_frame(in_frame));
  spi_eeprom_device #(.WRITE_CYCLES(WCYC)) spi_eeprom_device_inst(.clock(clock), .reset(reset),
    .link(link.device), .write_busy(write_busy), .suspended(suspended));
  spi_eeprom_asserts #(.WRITE_CYCLES(WCYC)) spi_eeprom_asserts_inst(.clock(clock), .reset(reset),
    .cs_n(link.cs_n), .sck(link.sck), .so(link.so), .so_oe(link.so_oe), .wp_n(link.wp_n),
    .hold_n(link.hold_n), .write_busy(write_busy), .suspended(suspended));
  initial begin
    forever #5 clock = ~clock;
  end
  // sampled off the edge, where registered outputs have settled
  always @(negedge clock) begin
    cyc <= cyc + 1;
    if (rx_valid) begin
      rxq.push_back(rx_data);
    end
    if (suspended) begin
      saw_susp <= 1'b1;
    end
    if (cyc == 90000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // valid stays up across bytes so the short gap between bytes is never missed
  task automatic frame(input logic [7:0] b[$]);
    int n;
    rxq = {};
    foreach (b[i]) begin
      @(negedge clock);
      tx_valid = 1'b1;
      tx_data = b[i];
      tx_last = (i == b.size() - 1);
      n = 0;
      // ready is read off the edge; when high, the coming rising edge takes the byte
      while (!tx_ready && n < 2000) begin
        @(negedge clock);
        n++;
      end
      check("host ready", 8'h01, {7'h00, tx_ready});
      @(posedge clock);
    end
    @(negedge clock);
    tx_valid = 1'b0;
    n = 0;
    while (in_frame && n < 4000) begin
      @(negedge clock);
      n++;
    end
    check("frame end", 8'h00, {7'h00, in_frame});
    repeat (8) @(negedge clock);
  endtask : frame
  task automatic idle();
    int n;
    n = 0;
    while (write_busy && n < 4 * WCYC) begin
      @(negedge clock);
      n++;
    end
    check("write done", 8'h00, {7'h00, write_busy});
    repeat (4) @(negedge clock);
  endtask : idle
  function automatic bit prot(int a);
    return bp == 3 || (bp == 2 && a >= 32'h40) || (bp == 1 && a >= 32'h60);
  endfunction : prot
  task automatic st(input logic [7:0] exp, input logic [7:0] mask);
    frame({spi_eeprom_pkg::OP_RDSR, 8'h00, 8'h00});
    check("status", exp, rxq[1] & mask);
    check("status repeat", exp, rxq[2] & mask);
  endtask : st
  // mode 1 drops protect mid-frame, mode 2 drops it during the write cycle
  task automatic wr(input int a, input logic [7:0] d, input int mode);
    frame({spi_eeprom_pkg::OP_WREN});
    fork
      frame({spi_eeprom_pkg::OP_WRITE, a[7:0], d});
      if (mode == 1) begin
        repeat (600) @(negedge clock);
        protect = 1'b1;
      end
    join
    if (!protect && !prot(a)) begin
      mem[a] = d;
    end
    // a protected address must not start a cycle either
    check("write busy", {7'h00, !protect && !prot(a)}, {7'h00, write_busy});
    if (mode == 2) begin
      protect = 1'b1;
    end
    idle();
    protect = 1'b0;
  endtask : wr
  task automatic rd(input int a, input int n);
    logic [7:0] q[$];
    q = {spi_eeprom_pkg::OP_READ, a[7:0]};
    repeat (n) q.push_back(8'h00);
    frame(q);
    for (int i = 0; i < n; i++) begin
      check("read data", mem[(a + i) % 128][7:0], rxq[i + 2]);
    end
  endtask : rd
  initial begin
    repeat (20) @(negedge clock);
    reset = 1'b0;
    repeat (10) @(negedge clock);
    st(8'h00, 8'hff);
    frame({spi_eeprom_pkg::OP_WREN});
    st(8'h02, 8'hff);
    frame({spi_eeprom_pkg::OP_WRDI});
    st(8'h00, 8'hff);
    for (int k = 0; k < 5; k++) begin
      frame({spi_eeprom_pkg::OP_WREN});
      frame({spi_eeprom_pkg::OP_WRSR, 8'(bps[k] << 2)});
      idle();
      bp = bps[k];
      st(8'(bps[k] << 2), 8'hfd);
      foreach (adr[i]) wr(adr[i], 8'($random(seed)), 0);
      foreach (adr[i]) rd(adr[i], 1);
    end
    wr(32'h7f, 8'($random(seed)), 0);
    wr(32'h00, 8'($random(seed)), 0);
    protect = 1'b1;
    wr(32'h3f, 8'($random(seed)), 0);
    wr(32'h00, 8'($random(seed)), 1);
    wr(32'h7f, 8'($random(seed)), 2);
    // a write without the enable latch must not start a cycle
    frame({spi_eeprom_pkg::OP_WRDI});
    frame({spi_eeprom_pkg::OP_WRITE, 8'h3f, 8'h00});
    check("busy without enable", 8'h00, {7'h00, write_busy});
    idle();
    fork
      rd(32'h7f, 2);
      begin
        repeat (600) @(negedge clock);
        hold_req = 1'b1;
        repeat (300) @(negedge clock);
        hold_req = 1'b0;
      end
    join
    check("pause seen", 8'h01, {7'h00, saw_susp});
    rd(32'h3f, 1);
    rd(32'h00, 1);
    print_verdict();
  end
endmodule : spi_eeprom_pin_interface_tb
`default_nettype wire
